// ==== core/xfs_defs.svh ====
`ifndef XFS_DEFS_SVH
`define XFS_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define XFS_OFS_FRAME_CFG   12'h000
`define XFS_OFS_CODES       12'h004
`define XFS_OFS_STATUS      12'h008

////////////////////////////////////////////////////////////////////////////////
// instruction_frame_config fields
`define XFS_WIDTH_LSB       0
`define XFS_INST_EN_BIT     4
`define XFS_ADDR_EN_BIT     5
`define XFS_OPT_EN_BIT      6
`define XFS_DATA_EN_BIT     7
`define XFS_OPT_LEN_LSB     8
`define XFS_ADDR_LEN_BIT    10
`define XFS_XFER_LSB        12
`define XFS_CONT_EN_BIT     14
`define XFS_DUMMY_LSB       16
`define XFS_FRAME_CFG_MASK  32'h001f_77f7

// code register: read instruction, entry option code, exit option code
`define XFS_INST_LSB        0
`define XFS_OPT_LSB         16
`define XFS_EXIT_LSB        24

`define XFS_FRAME_CFG_RST   32'h0000_0000
`define XFS_CODES_RST       32'h0000_0000

////////////////////////////////////////////////////////////////////////////////
// memory window
`define XFS_WIN_BASE        32'h8000_0000
`define XFS_WIN_MASK        32'hf000_0000

////////////////////////////////////////////////////////////////////////////////
// timing
`define XFS_MCLK_NS         10
`define XFS_SCK_NS          40
`define XFS_SCK_DIV         (`XFS_SCK_NS / `XFS_MCLK_NS)

`define XFS_FIFO_WIDTH      32
`define XFS_FIFO_DEPTH      16

`endif

// ==== core/xfs_pkg.sv ====
package xfs_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_INST  = 3'b001,
    ST_ADDR  = 3'b010,
    ST_OPT   = 3'b011,
    ST_DUMMY = 3'b100,
    ST_DATA  = 3'b101,
    ST_PUSH  = 3'b110,
    ST_GAP   = 3'b111
  } xfs_state_t;

  typedef enum logic [1:0] {
    XFER_REG_RD = 2'b00,
    XFER_MEM_RD = 2'b01,
    XFER_REG_WR = 2'b10,
    XFER_MEM_WR = 2'b11
  } xfs_xfer_t;

endpackage : xfs_pkg

// ==== core/xfs_xip_read.sv ====
`timescale 1ns/10ps
`include "xfs_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// word buffer between the flash sequencer and the system bus
module xfs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output wire logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output wire logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [AW:0]      cnt_r;

  wire push = in_valid && in_ready;
  // output stage is a register so the top sees flop-driven data
  wire pop  = (cnt_r != '0) && (!out_valid || out_ready);

  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign count    = cnt_r;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wptr_r] <= in_data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wptr_r    <= '0;
      rptr_r    <= '0;
      cnt_r     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r   <= rptr_r + 1'b1;
        out_data <= mem[rptr_r];
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      if (pop) begin
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule : xfs_fifo

////////////////////////////////////////////////////////////////////////////////
module xfs_xip_read (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sys_req,
  input  wire logic [31:0] sys_addr,
  output logic             sys_req_ready,
  output logic             sys_rvalid,
  output logic      [31:0] sys_rdata,
  input  wire logic        sys_rready,
  output logic             fl_sck,
  output logic             fl_cs_n,
  output logic      [3:0]  fl_io_out,
  output logic      [3:0]  fl_io_oe_n,
  input  wire logic [3:0]  fl_io_in
);
  import xfs_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [31:0]     frame_cfg_r;
  logic [31:0]     codes_r;
  logic            cont_active_r;
  logic            exit_pending_r;
  xfs_state_t      state_r;
  xfs_state_t      state_nxt;
  logic [4:0]      cnt_r;
  logic [31:0]     sh_r;
  logic [31:0]     rx_r;
  logic [31:0]     faddr_r;
  logic [1:0]      div_r;
  logic [3:0]      io_s1_r;
  logic [3:0]      io_s2_r;
  logic [4:0]      fifo_cnt;
  logic            fifo_in_ready;

  //////////////////////////////////////////////////////////////////////////////
  // frame configuration decode
  wire       inst_en      = frame_cfg_r[`XFS_INST_EN_BIT];
  wire       opt_en       = frame_cfg_r[`XFS_OPT_EN_BIT];
  wire       data_en      = frame_cfg_r[`XFS_DATA_EN_BIT];
  wire [1:0] opt_len      = frame_cfg_r[`XFS_OPT_LEN_LSB +: 2];
  wire       addr32       = frame_cfg_r[`XFS_ADDR_LEN_BIT];
  wire [1:0] xfer_type    = frame_cfg_r[`XFS_XFER_LSB +: 2];
  wire       cont_en      = frame_cfg_r[`XFS_CONT_EN_BIT];
  wire [4:0] dummy_clks   = frame_cfg_r[`XFS_DUMMY_LSB +: 5];
  wire       mem_read     = (xfer_type == XFER_MEM_RD);
  wire       cont_eff     = cont_en && mem_read;
  wire       xip_on       = data_en && mem_read;
  // flash still holds the instruction but controller no longer wants it
  wire       need_exit    = cont_active_r && !cont_eff;
  // the exit frame skips it too: the flash still expects no instruction
  wire       skip_inst    = cont_active_r;
  wire       send_inst    = inst_en && !skip_inst;
  wire       opt_on       = opt_en || need_exit;
  wire [7:0] opt_code     = need_exit ? codes_r[`XFS_EXIT_LSB +: 8]
                                      : codes_r[`XFS_OPT_LSB +: 8];
  wire [4:0] addr_clks    = addr32 ? 5'd8 : 5'd6;
  wire [4:0] opt_clks     = (opt_len == 2'b11) ? 5'd2 : 5'd1;
  wire       win_hit      = ((sys_addr & `XFS_WIN_MASK) == `XFS_WIN_BASE);

  //////////////////////////////////////////////////////////////////////////////
  // sequencer control
  wire       tick         = (div_r == 2'(`XFS_SCK_DIV - 1));
  wire       last_clk     = tick && (cnt_r == 5'd1);
  wire       take         = (state_r == ST_IDLE) && sys_req && !sys_req_ready &&
                            win_hit && xip_on && fifo_in_ready;
  wire       after_addr_d = (dummy_clks != 5'd0);
  wire       active       = (state_r != ST_IDLE) && (state_r != ST_PUSH);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt = send_inst ? ST_INST : ST_ADDR;
        end
      end
      ST_INST: begin
        if (last_clk) begin
          state_nxt = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (last_clk) begin
          state_nxt = opt_on ? ST_OPT : (after_addr_d ? ST_DUMMY : ST_DATA);
        end
      end
      ST_OPT: begin
        if (last_clk) begin
          state_nxt = after_addr_d ? ST_DUMMY : ST_DATA;
        end
      end
      ST_DUMMY: begin
        if (last_clk) begin
          state_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        if (last_clk) begin
          state_nxt = ST_PUSH;
        end
      end
      ST_PUSH: begin
        // a full buffer holds the sequencer here
        if (fifo_in_ready) begin
          state_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        if (tick) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  wire entering  = (state_nxt != state_r);
  wire [31:0] addr_word = addr32 ? faddr_r : {faddr_r[23:0], 8'h00};
  wire [31:0] sys_word  = addr32 ? sys_addr : {sys_addr[23:0], 8'h00};

  // per-phase length and shift load
  wire [4:0] cnt_load =
      (state_nxt == ST_INST)  ? 5'd2 :
      (state_nxt == ST_ADDR)  ? addr_clks :
      (state_nxt == ST_OPT)   ? opt_clks :
      (state_nxt == ST_DUMMY) ? dummy_clks :
      (state_nxt == ST_DATA)  ? 5'd8 :
      (state_nxt == ST_GAP)   ? 5'd1 : 5'd0;
  wire [31:0] sh_load =
      (state_nxt == ST_INST) ? {codes_r[`XFS_INST_LSB +: 8], 24'h0} :
      (state_nxt == ST_ADDR) ? ((state_r == ST_IDLE) ? sys_word : addr_word) :
      (state_nxt == ST_OPT)  ? {opt_code, 24'h0} : 32'h0;
  // pins driven only while the controller sends
  wire drive_nxt = (state_nxt == ST_INST) || (state_nxt == ST_ADDR) ||
                   (state_nxt == ST_OPT);

  //////////////////////////////////////////////////////////////////////////////
  // link side
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
    end else begin
      io_s1_r <= fl_io_in;
      io_s2_r <= io_s1_r;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r   <= 5'd0;
      sh_r    <= 32'h0;
      div_r   <= 2'd0;
    end else begin
      state_r <= state_nxt;
      if (entering) begin
        cnt_r <= cnt_load;
        sh_r  <= sh_load;
        div_r <= 2'd0;
      end else if (active) begin
        div_r <= tick ? 2'd0 : div_r + 2'd1;
        if (tick) begin
          cnt_r <= cnt_r - 5'd1;
          sh_r  <= {sh_r[27:0], 4'h0};
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fl_sck     <= 1'b0;
      fl_cs_n    <= 1'b1;
      fl_io_out  <= 4'h0;
      fl_io_oe_n <= 4'hf;
    end else begin
      fl_sck <= active && !entering && (state_r != ST_GAP) &&
                (div_r == 2'(`XFS_SCK_DIV / 2 - 1) || (fl_sck && !tick));
      fl_cs_n <= !((state_nxt != ST_IDLE) && (state_nxt != ST_GAP));
      if (entering) begin
        fl_io_out  <= sh_load[31:28];
        fl_io_oe_n <= {4{!drive_nxt}};
      end else if (tick) begin
        fl_io_out <= sh_r[27:24];
      end
    end
  end

  // lines sampled at the link clock rising edge, loaded at the falling edge after two sync stages, nibbles msb first
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_r <= 32'h0;
    end else if (state_r == ST_DATA && tick) begin
      rx_r <= {rx_r[27:0], io_s2_r};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      faddr_r        <= 32'h0;
      sys_req_ready  <= 1'b0;
      cont_active_r  <= 1'b0;
      exit_pending_r <= 1'b0;
    end else begin
      sys_req_ready <= take;
      if (take) begin
        faddr_r        <= sys_addr;
        exit_pending_r <= need_exit;
      end
      // flash enters or leaves continuous read with the frame's option code
      if (state_r == ST_DATA && last_clk) begin
        if (exit_pending_r) begin
          cont_active_r <= 1'b0;
        end else if (cont_eff && opt_en) begin
          cont_active_r <= 1'b1;
        end
      end
    end
  end

  xfs_fifo #(
    .WIDTH (`XFS_FIFO_WIDTH),
    .DEPTH (`XFS_FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (state_r == ST_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_r),
    .out_valid (sys_rvalid),
    .out_ready (sys_rready),
    .out_data  (sys_rdata),
    .count     (fifo_cnt)
  );

  //////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  wire        apb_setup = psel && !penable;
  wire        apb_done  = psel && penable && pready;
  wire        hit_cfg   = (paddr == `XFS_OFS_FRAME_CFG);
  wire        hit_codes = (paddr == `XFS_OFS_CODES);
  wire        hit_stat  = (paddr == `XFS_OFS_STATUS);
  wire        hit_any   = hit_cfg || hit_codes || hit_stat;
  wire [31:0] bmask     = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [31:0] status_w  = {24'h0, fifo_cnt, state_r != ST_IDLE, cont_active_r, xip_on};
  wire [31:0] rd_mux    = hit_cfg   ? frame_cfg_r :
                          hit_codes ? codes_r :
                          hit_stat  ? status_w : 32'h0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup && !hit_any;
      prdata  <= (apb_setup && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // reserved frame config bits stay zero, code bits 15:8 keep what is written; status is read only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      frame_cfg_r <= `XFS_FRAME_CFG_RST;
      codes_r     <= `XFS_CODES_RST;
    end else if (apb_done && pwrite) begin
      if (hit_cfg) begin
        frame_cfg_r <= ((frame_cfg_r & ~bmask) | (pwdata & bmask)) & `XFS_FRAME_CFG_MASK;
      end
      if (hit_codes) begin
        codes_r <= (codes_r & ~bmask) | (pwdata & bmask);
      end
    end
  end
endmodule : xfs_xip_read

// ==== verif/xfs_xip_read_monitor.sv ====
`timescale 1ns/10ps
module xfs_xip_read_monitor (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sys_req,
  input wire logic [31:0] sys_addr,
  input wire logic        sys_req_ready,
  input wire logic        sys_rvalid,
  input wire logic [31:0] sys_rdata,
  input wire logic        sys_rready,
  input wire logic        fl_sck,
  input wire logic        fl_cs_n,
  input wire logic [3:0]  fl_io_out,
  input wire logic [3:0]  fl_io_oe_n
);
  default clocking mon_cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////
  sequence s_sck_pulse;
    fl_sck [*2] ##1 !fl_sck;
  endsequence
  sequence s_frame_open;
    !fl_cs_n [*8];
  endsequence
  ////////////////////////////////////////////////
  AST_APB_ANSWER: assert property (psel && !penable |=> pready)
    else $error("apb setup not answered");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  AST_TAKE_IN_WINDOW: assert property (sys_req_ready |->
    $past(sys_req) && $past(sys_addr[31:28]) == 4'h8)
    else $error("request taken outside window");
  AST_TAKE_OPENS_FRAME: assert property (sys_req_ready |-> s_frame_open)
    else $error("taken request opened no frame");
  AST_CS_GAP: assert property ($rose(fl_cs_n) |-> fl_cs_n [*4])
    else $error("frame gap too short");
  AST_SCK_SHAPE: assert property ($rose(fl_sck) |-> s_sck_pulse)
    else $error("link clock pulse misshaped");
  AST_SCK_IN_FRAME: assert property (fl_cs_n |-> !fl_sck)
    else $error("link clock outside frame");
  AST_QUAD_LINES: assert property (fl_io_oe_n == 4'h0 || fl_io_oe_n == 4'hf)
    else $error("data lines not driven as four");
  AST_IO_HOLD: assert property (fl_sck |-> $stable(fl_io_out))
    else $error("data changed while clock high");
  AST_WORD_HELD: assert property (sys_rvalid && !sys_rready |=>
    sys_rvalid && $stable(sys_rdata))
    else $error("read word dropped before taken");
endmodule : xfs_xip_read_monitor

bind xfs_xip_read xfs_xip_read_monitor xfs_xip_read_monitor_inst (.*);

// ==== verif/xfs_flash_model.sv ====
`timescale 1ns/10ps
module xfs_flash_model #(
  parameter logic [7:0] INST      = 8'h6b,
  parameter logic [3:0] ENTRY_NIB = 4'ha,
  parameter int         DUMMY     = 4
) (
  input wire logic       fl_sck,
  input wire logic       fl_cs_n,
  input wire logic [3:0] fl_io_out,
  output logic     [3:0] fl_dq
);
  int          k;
  int          pre;
  logic        cont;
  logic [7:0]  ins;
  logic [23:0] adr;
  logic [31:0] word;
  initial begin
    cont = 1'b0;
    fl_dq = 4'h5;
  end
  ////////////////////////////////////////////////
  // stored instruction stands in when the frame omits it
  always @(negedge fl_cs_n) begin
    k = 0;
    pre = cont ? 0 : 2;
    ins = cont ? INST : 8'h00;
  end
  always @(posedge fl_cs_n) fl_dq = ~fl_dq;
  always @(posedge fl_sck) begin
    if (!fl_cs_n) begin
      if (k < pre)
        ins = {ins[3:0], fl_io_out};
      else if (k < pre + 6)
        adr = {adr[19:0], fl_io_out};
      else if (k == pre + 6)
        cont = (fl_io_out == ENTRY_NIB) && (ins == INST);
      k = k + 1;
    end
  end
  // unknown instruction reads zeros; released lines toggle so stale data never matches
  always @(negedge fl_sck) begin
    word = (ins == INST) ? {8'h5a, adr} : 32'h0;
    if (!fl_cs_n && k >= pre + 7 + DUMMY && k < pre + 15 + DUMMY)
      fl_dq = word[31 - 4 * (k - pre - 7 - DUMMY) -: 4];
    else
      fl_dq = ~fl_dq;
  end
endmodule : xfs_flash_model

// ==== verif/xfs_xip_read_bench.sv ====
`timescale 1ns/10ps
module xfs_xip_read_bench;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, e, got;
  logic        sys_req, sys_req_ready, sys_rvalid, sys_rready, fl_sck, fl_cs_n, sck_q, cs_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, sys_addr, sys_rdata, rd, cfg_w;
  logic [3:0]  pstrb, fl_io_out, fl_io_oe_n, fl_io_in, fl_dq, io_line;
  int          n_mismatch, cmp_count, sck_cnt, frame_clks, k;
  int          cyc = 0;

  xfs_xip_read xfs_xip_read_inst (.*);
  xfs_flash_model xfs_flash_model_inst (.fl_sck, .fl_cs_n, .fl_io_out(io_line), .fl_dq);
  // shared lines: controller while its enable is low, flash otherwise
  assign io_line  = (fl_io_out & ~fl_io_oe_n) | (fl_dq & fl_io_oe_n);
  assign fl_io_in = io_line;

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // link clocks per frame, latched when chip select rises
  always @(posedge mclk) begin
    sck_q <= fl_sck;
    cs_q <= fl_cs_n;
    if (fl_cs_n && !cs_q) frame_clks <= sck_cnt;
    if (fl_cs_n) sck_cnt <= 0;
    else if (fl_sck && !sck_q) sck_cnt <= sck_cnt + 1;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // request held until pready is seen high at a rising edge; read data taken there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // a request not taken within the bound counts as refused
  task automatic req(input logic [31:0] a, output logic took);
    int n;
    n = 0;
    @(posedge mclk);
    sys_req <= 1'b1;
    sys_addr <= a;
    @(posedge mclk);
    while (sys_req_ready !== 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    took = (sys_req_ready === 1'b1);
    sys_req <= 1'b0;
  endtask : req
  // word taken at the edge where valid and ready both stand
  task automatic pop(output logic [31:0] w);
    @(posedge mclk);
    sys_rready <= 1'b1;
    @(posedge mclk);
    while (sys_rvalid !== 1'b1) @(posedge mclk);
    w = sys_rdata;
    sys_rready <= 1'b0;
  endtask : pop
  task automatic rd_frame(input logic [31:0] a, input int clks);
    req(a, got);
    chk("taken", 32'h1, got);
    pop(rd);
    chk("rdata", {8'h5a, a[23:0]}, rd);
    chk("frame clocks", 32'(clks), 32'(frame_clks));
  endtask : rd_frame
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////
  initial begin
    {rst, pstrb} = 5'h1f;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {sys_req, sys_addr, sys_rready, n_mismatch, cmp_count} = '0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0, rd, e);
    chk("cfg reset", 32'h0, rd);
    apb(1'b0, 12'h00c, 32'h0, rd, e);
    chk("unmapped err", 32'h1, e);
    chk("unmapped data", 32'h0, rd);
    req(32'h8000_0100, got);
    chk("taken while off", 32'h0, got);
    // every wrong type, and memory read without data phase, must not serve reads
    for (int t = 0; t < 4; t++) begin
      cfg_w = (t == 1) ? 32'h0004_5070 : (32'h0004_40f0 | (32'(t) << 12));
      apb(1'b1, 12'h000, cfg_w, rd, e);
      apb(1'b0, 12'h000, 32'h0, rd, e);
      chk("cfg", cfg_w, rd);
      req(32'h8000_0200, got);
      chk("taken bad type", 32'h0, got);
    end
    apb(1'b1, 12'h004, 32'hf0f0_006b, rd, e);
    apb(1'b1, 12'h000, 32'h0004_12f0, rd, e);
    req(32'h9000_0000, got);
    chk("taken outside", 32'h0, got);
    rd_frame(32'h8012_3450, 21);
    rd_frame(32'h8000_0a04, 21);
    apb(1'b0, 12'h008, 32'h0, rd, e);
    chk("status", 32'h1, {30'h0, rd[1:0]});
    apb(1'b1, 12'h004, 32'hf0a0_006b, rd, e);
    apb(1'b1, 12'h000, 32'h0004_52f0, rd, e);
    rd_frame(32'h8034_5670, 21);
    apb(1'b0, 12'h008, 32'h0, rd, e);
    chk("status cont", 32'h3, {30'h0, rd[1:0]});
    rd_frame(32'h8000_1238, 19);
    // stall the consumer until the buffer refuses, then drain it
    for (k = 0; k < 20; k++) begin
      req(32'h8001_0000 + (32'(k) << 4), got);
      if (!got) break;
    end
    chk("buffer words", 32'h1, (k == 16 || k == 17));
    for (int i = 0; i < k; i++) begin
      pop(rd);
      chk("buffer data", {8'h5a, 24'h01_0000 + 24'(i * 16)}, rd);
    end
    chk("frame clocks", 32'd19, 32'(frame_clks));
    apb(1'b1, 12'h000, 32'h0004_12f0, rd, e);
    // exit frame: flash still in continuous read, so no instruction yet
    rd_frame(32'h8055_5550, 19);
    apb(1'b0, 12'h008, 32'h0, rd, e);
    chk("status exit", 32'h1, {30'h0, rd[1:0]});
    rd_frame(32'h8066_6660, 21);
    report_and_stop();
  end
endmodule : xfs_xip_read_bench
